// *** bench/testbench.sv ***
// reader and tag joined back to back, driven by command sequences
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] ID = 8'h35;
  logic sys_clk_in, rst_in, field_ok, cmd_valid, cmd_ready;
  logic [3:0] cmd_len, rsp_len, acc_len;
  logic [63:0] cmd_data, rsp_data, acc_data;
  logic [39:0] acc_arg;
  logic rsp_valid, rsp_ok, acc_req, acc_rsp;
  logic [7:0] acc_op, sel_id;
  tsac_pkg::tsac_state_t state;
  int err_total = 0;
  int samples_checked = 0;

  tsac_link_if link_bus ();
  tsac_reader tsac_reader_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .link(link_bus.reader), .cmd_valid_in(cmd_valid), .cmd_len_in(cmd_len),
    .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_len_out(rsp_len),
    .rsp_data_out(rsp_data), .rsp_crc_ok_out(rsp_ok));
  // fixed identifier: slot code is its low nibble, 5
  tsac_tag #(.FIXED_ID_EN(1'b1), .FIXED_ID(ID)) tsac_tag_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .field_ok_in(field_ok),
    .link(link_bus.tag), .access_valid_out(acc_req), .access_op_out(acc_op),
    .access_arg_out(acc_arg), .access_rsp_valid_in(acc_rsp),
    .access_rsp_len_in(acc_len), .access_rsp_data_in(acc_data),
    .state_out(state), .select_identifier_out(sel_id));
  tsac_link_monitor tsac_link_monitor_inst (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .rq_valid(link_bus.rq_valid),
    .rq_kind(link_bus.rq_kind), .rq_char(link_bus.rq_char),
    .an_valid(link_bus.an_valid), .an_kind(link_bus.an_kind),
    .an_char(link_bus.an_char));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // memory side: answers each access with four bytes, writes with none
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      acc_rsp <= 1'b0;
      acc_len <= 4'h0;
      acc_data <= 64'h0;
    end else begin
      acc_rsp <= acc_req;
      acc_len <= (acc_op == tsac_pkg::TSAC_OP_WRITE) ? 4'h0 : 4'h4;
      acc_data <= {56'h0, acc_op ^ 8'hf0};
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // sends one request, expects n reply bytes (0 = silence) led by b0
  task automatic xfer(input logic [3:0] len, input logic [7:0] op,
                      input logic [7:0] arg, input logic [3:0] n,
                      input logic [7:0] b0);
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk_in);
    cmd_valid <= 1'b1;
    cmd_len <= len;
    cmd_data <= {48'h0, arg, op};
    do @(posedge sys_clk_in); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge sys_clk_in);
      if (rsp_valid === 1'b1) begin
        seen = 1'b1;
        check(64'(rsp_len), 64'(n));
        check(64'(rsp_data[7:0]), 64'(b0));
        check(64'(rsp_ok), 64'h1);
      end
    end
    check(64'(seen), 64'(n != 4'h0));
  endtask : xfer

  task automatic st(input tsac_pkg::tsac_state_t s, input string name);
    check(64'(state), 64'(s));
    $display("test %s done", name);
  endtask : st

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    finish_test();
  end

  initial begin
    rst_in = 1'b1;
    field_ok = 1'b1;
    cmd_valid = 1'b0;
    cmd_len = 4'h0;
    cmd_data = 64'h0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    xfer(4'h2, 8'h06, 8'h04, 4'h0, 8'h00);
    xfer(4'h2, 8'h0e, ID, 4'h0, 8'h00);
    st(tsac_pkg::TSAC_ST_READY, "ready");
    xfer(4'h2, 8'h06, 8'h00, 4'h1, ID);
    xfer(4'h1, 8'h55, 8'h00, 4'h0, 8'h00);
    xfer(4'h2, 8'h06, 8'h04, 4'h0, 8'h00);
    for (int sn = 1; sn < 16; sn++) begin
      xfer(4'h1, {4'(sn), 4'h6}, 8'h00, 4'(sn == 5), ID);
    end
    xfer(4'h2, 8'h06, 8'h00, 4'h1, ID);
    check(64'(sel_id), 64'(ID));
    xfer(4'h2, 8'h0e, ID ^ 8'h01, 4'h0, 8'h00);
    st(tsac_pkg::TSAC_ST_INV, "inventory");
    xfer(4'h2, 8'h0e, ID, 4'h1, ID);
    xfer(4'h1, 8'h56, 8'h00, 4'h0, 8'h00);
    xfer(4'h2, 8'h06, 8'h04, 4'h0, 8'h00);
    xfer(4'h2, 8'h08, 8'h07, 4'h4, 8'hf8);
    xfer(4'h6, 8'h09, 8'h07, 4'h0, 8'h00);
    check(64'(acc_arg), 64'h0000_0000_0000_0007);
    xfer(4'h2, 8'h0a, 8'h01, 4'h4, 8'hfa);
    xfer(4'h1, 8'h0b, 8'h00, 4'h4, 8'hfb);
    st(tsac_pkg::TSAC_ST_SEL, "selected");
    xfer(4'h2, 8'h0e, 8'h22, 4'h0, 8'h00);
    xfer(4'h2, 8'h08, 8'h07, 4'h0, 8'h00);
    st(tsac_pkg::TSAC_ST_DESEL, "deselect");
    xfer(4'h2, 8'h0e, ID, 4'h1, ID);
    xfer(4'h1, 8'h0f, 8'h00, 4'h0, 8'h00);
    xfer(4'h2, 8'h06, 8'h00, 4'h0, 8'h00);
    xfer(4'h2, 8'h0e, ID, 4'h0, 8'h00);
    st(tsac_pkg::TSAC_ST_DEACT, "deactivated");
    @(posedge sys_clk_in);
    field_ok <= 1'b0;
    xfer(4'h2, 8'h06, 8'h00, 4'h0, 8'h00);
    st(tsac_pkg::TSAC_ST_OFF, "power off");
    @(posedge sys_clk_in);
    field_ok <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    st(tsac_pkg::TSAC_ST_READY, "power up");
    check(64'(sel_id), 64'(ID));
    xfer(4'h2, 8'h06, 8'h00, 4'h1, ID);
    finish_test();
  end
endmodule : testbench

// *** bench/tsac_link_monitor.sv ***
// wire-level assertions on the reader/tag character link
`timescale 1ns/1ns
module tsac_link_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic rq_valid,
  input wire tsac_pkg::tsac_kind_t rq_kind,
  input wire logic [9:0] rq_char,
  input wire logic an_valid,
  input wire tsac_pkg::tsac_kind_t an_kind,
  input wire logic [9:0] an_char
);
  logic rq_in_q;
  logic an_in_q;
  wire rq_sof = rq_valid && rq_kind == tsac_pkg::TSAC_K_SOF;
  wire rq_chr = rq_valid && rq_kind == tsac_pkg::TSAC_K_CHAR;
  wire rq_eof = rq_valid && rq_kind == tsac_pkg::TSAC_K_EOF;
  wire an_sof = an_valid && an_kind == tsac_pkg::TSAC_K_SOF;
  wire an_chr = an_valid && an_kind == tsac_pkg::TSAC_K_CHAR;
  wire an_eof = an_valid && an_kind == tsac_pkg::TSAC_K_EOF;

  // open-frame trackers for each direction
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) rq_in_q <= 1'b0;
    else if (rq_sof) rq_in_q <= 1'b1;
    else if (rq_eof) rq_in_q <= 1'b0;
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) an_in_q <= 1'b0;
    else if (an_sof) an_in_q <= 1'b1;
    else if (an_eof) an_in_q <= 1'b0;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_rq_char_bits: assert property (rq_chr |-> !rq_char[0] && rq_char[9])
    else $error("request char start or stop bit wrong");
  a_an_char_bits: assert property (an_chr |-> !an_char[0] && an_char[9])
    else $error("answer char start or stop bit wrong");
  a_rq_frame_min: assert property (rq_sof |=> rq_chr [*3])
    else $error("request frame shorter than data plus crc");
  a_an_frame_min: assert property (an_sof |=> an_chr [*3])
    else $error("answer frame shorter than data plus crc");
  a_an_eof_bound: assert property (an_sof |-> ##[4:11] an_eof)
    else $error("answer frame not closed in time");
  a_an_sof_nest: assert property (an_sof |-> !an_in_q)
    else $error("answer start inside open frame");
  a_an_body_inside: assert property ((an_chr || an_eof) |-> an_in_q)
    else $error("answer char or end outside frame");
  a_an_during_rq: assert property (rq_in_q |-> !an_valid)
    else $error("tag talks during a request frame");
  a_link_quiet_reset: assert property (@(posedge sys_clk_in)
    disable iff (1'b0) rst_in |=> !an_valid && !rq_valid)
    else $error("link active during reset");
endmodule : tsac_link_monitor

// *** rtl/tsac_framer.sv ***
// sends one frame: sof, data characters, two crc bytes, eof
`timescale 1ns/1ns
module tsac_framer (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic abort_in,
  input wire logic start_in,
  input wire logic [3:0] len_in,
  input wire logic [63:0] data_in,
  output logic busy_out,
  output logic valid_out,
  output tsac_pkg::tsac_kind_t kind_out,
  output logic [9:0] char_out
);

  typedef enum logic [5:0] {
    TSAC_FR_IDLE = 6'h01,
    TSAC_FR_SOF = 6'h02,
    TSAC_FR_DATA = 6'h04,
    TSAC_FR_CRCL = 6'h08,
    TSAC_FR_CRCH = 6'h10,
    TSAC_FR_EOF = 6'h20
  } tsac_fr_t;

  tsac_fr_t fr_q;
  logic [63:0] data_q;
  logic [3:0] len_q;
  logic [2:0] idx_q;
  logic [15:0] crc_q;
  logic [7:0] cur_byte;

  assign cur_byte = data_q[{idx_q, 3'b000} +: 8];
  assign busy_out = (fr_q != TSAC_FR_IDLE);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || abort_in) begin
      fr_q <= TSAC_FR_IDLE;
      valid_out <= 1'b0;
      kind_out <= tsac_pkg::TSAC_K_SOF;
      char_out <= 10'h000;
      idx_q <= 3'h0;
      crc_q <= tsac_pkg::TSAC_CRC_INIT;
      len_q <= 4'h0;
      data_q <= 64'h0000_0000_0000_0000;
    end else begin
      valid_out <= 1'b0;
      unique case (fr_q)
        TSAC_FR_IDLE: if (start_in) begin
          data_q <= data_in;
          len_q <= len_in;
          idx_q <= 3'h0;
          crc_q <= tsac_pkg::TSAC_CRC_INIT;
          fr_q <= TSAC_FR_SOF;
        end
        TSAC_FR_SOF: begin
          valid_out <= 1'b1;
          kind_out <= tsac_pkg::TSAC_K_SOF;
          fr_q <= TSAC_FR_DATA;
        end
        TSAC_FR_DATA: begin
          valid_out <= 1'b1;
          kind_out <= tsac_pkg::TSAC_K_CHAR;
          char_out <= tsac_pkg::tsac_char_pack(cur_byte);
          crc_q <= tsac_pkg::tsac_crc_byte(crc_q, cur_byte);
          idx_q <= idx_q + 3'h1;
          if ({1'b0, idx_q} == len_q - 4'h1) begin
            fr_q <= TSAC_FR_CRCL;
          end
        end
        TSAC_FR_CRCL: begin
          valid_out <= 1'b1;
          char_out <= tsac_pkg::tsac_char_pack(~crc_q[7:0]);
          fr_q <= TSAC_FR_CRCH;
        end
        TSAC_FR_CRCH: begin
          valid_out <= 1'b1;
          char_out <= tsac_pkg::tsac_char_pack(~crc_q[15:8]);
          fr_q <= TSAC_FR_EOF;
        end
        TSAC_FR_EOF: begin
          valid_out <= 1'b1;
          kind_out <= tsac_pkg::TSAC_K_EOF;
          fr_q <= TSAC_FR_IDLE;
        end
      endcase
    end
  end

endmodule : tsac_framer

// *** rtl/tsac_link_if.sv ***
// character link between reader and tag
`timescale 1ns/1ns
interface tsac_link_if;
  logic rq_valid;
  tsac_pkg::tsac_kind_t rq_kind;
  logic [9:0] rq_char;
  logic an_valid;
  tsac_pkg::tsac_kind_t an_kind;
  logic [9:0] an_char;

  modport reader (
    output rq_valid, rq_kind, rq_char,
    input an_valid, an_kind, an_char
  );

  modport tag (
    input rq_valid, rq_kind, rq_char,
    output an_valid, an_kind, an_char
  );
endinterface : tsac_link_if

// *** rtl/tsac_pkg.sv ***
// shared constants, types and helpers for the tag command link
package tsac_pkg;

  // character layout: start bit at position 0 goes first, stop bit last
  localparam int TSAC_CHAR_W = 10;
  localparam int TSAC_START_POS = 0;
  localparam int TSAC_STOP_POS = 9;

  // frame sizes in bytes
  localparam int TSAC_BUF_BYTES = 8;
  localparam int TSAC_CRC_BYTES = 2;
  localparam int TSAC_FRAME_BYTES = TSAC_BUF_BYTES + TSAC_CRC_BYTES;
  localparam logic [3:0] TSAC_MIN_FRAME = 4'h3;

  // reflected crc, init all ones, inverted on send, low byte first
  localparam logic [15:0] TSAC_CRC_INIT = 16'hffff;
  localparam logic [15:0] TSAC_CRC_POLY = 16'h8408;
  localparam logic [15:0] TSAC_CRC_RESIDUE = 16'hf0b8;

  // command codes and request lengths (without crc)
  localparam logic [7:0] TSAC_OP_ANTICOL = 8'h06;
  localparam logic [7:0] TSAC_ARG_INIT = 8'h00;
  localparam logic [7:0] TSAC_ARG_PCALL = 8'h04;
  localparam logic [3:0] TSAC_SLOT_MARK = 4'h6;
  localparam logic [3:0] TSAC_SLOT_ZERO = 4'h0;
  localparam logic [7:0] TSAC_OP_SELECT = 8'h0e;
  localparam logic [7:0] TSAC_OP_COMPLETE = 8'h0f;
  localparam logic [7:0] TSAC_OP_READ = 8'h08;
  localparam logic [7:0] TSAC_OP_WRITE = 8'h09;
  localparam logic [7:0] TSAC_OP_AUTH = 8'h0a;
  localparam logic [7:0] TSAC_OP_UID = 8'h0b;
  localparam logic [3:0] TSAC_LEN_ANTICOL = 4'h2;
  localparam logic [3:0] TSAC_LEN_SLOT = 4'h1;
  localparam logic [3:0] TSAC_LEN_SELECT = 4'h2;
  localparam logic [3:0] TSAC_LEN_COMPLETE = 4'h1;
  localparam logic [3:0] TSAC_LEN_READ = 4'h2;
  localparam logic [3:0] TSAC_LEN_WRITE = 4'h6;
  localparam logic [3:0] TSAC_LEN_AUTH = 4'h2;
  localparam logic [3:0] TSAC_LEN_UID = 4'h1;
  localparam logic [3:0] TSAC_LEN_ID_REPLY = 4'h1;

  // random source
  localparam logic [15:0] TSAC_LFSR_SEED = 16'hace1;
  localparam logic [15:0] TSAC_LFSR_TAPS = 16'hb400;

  typedef enum logic [1:0] {
    TSAC_K_SOF = 2'h0,
    TSAC_K_CHAR = 2'h1,
    TSAC_K_EOF = 2'h2
  } tsac_kind_t;

  typedef enum logic [5:0] {
    TSAC_ST_OFF = 6'h01,
    TSAC_ST_READY = 6'h02,
    TSAC_ST_INV = 6'h04,
    TSAC_ST_SEL = 6'h08,
    TSAC_ST_DESEL = 6'h10,
    TSAC_ST_DEACT = 6'h20
  } tsac_state_t;

  function automatic logic [9:0] tsac_char_pack(input logic [7:0] b);
    return {1'b1, b, 1'b0};
  endfunction : tsac_char_pack

  function automatic logic tsac_char_ok(input logic [9:0] c);
    return !c[TSAC_START_POS] && c[TSAC_STOP_POS];
  endfunction : tsac_char_ok

  function automatic logic [15:0] tsac_crc_byte(input logic [15:0] c,
                                                input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ TSAC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : tsac_crc_byte

endpackage : tsac_pkg

// *** rtl/tsac_reader.sv ***
// reader end: frames user commands, collects and checks answers
`timescale 1ns/1ns
module tsac_reader (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  tsac_link_if.reader link,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_len_in,
  input wire logic [63:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [3:0] rsp_len_out,
  output logic [63:0] rsp_data_out,
  output logic rsp_crc_ok_out
);

  logic tx_busy;
  logic rx_open_q;
  logic rx_bad_q;
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic [7:0] rx_buf_q [tsac_pkg::TSAC_FRAME_BYTES];

  assign cmd_ready_out = !tx_busy;

  // command order is the user's; each with nonzero length is one frame
  tsac_framer u_framer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .abort_in(1'b0),
    .start_in(cmd_valid_in && !tx_busy && cmd_len_in != 4'h0),
    .len_in(cmd_len_in),
    .data_in(cmd_data_in),
    .busy_out(tx_busy),
    .valid_out(link.rq_valid),
    .kind_out(link.rq_kind),
    .char_out(link.rq_char)
  );

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_open_q <= 1'b0;
      rx_bad_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_crc_q <= tsac_pkg::TSAC_CRC_INIT;
    end else if (link.an_valid) begin
      unique case (link.an_kind)
        tsac_pkg::TSAC_K_SOF: begin
          rx_open_q <= 1'b1;
          rx_bad_q <= 1'b0;
          rx_cnt_q <= 4'h0;
          rx_crc_q <= tsac_pkg::TSAC_CRC_INIT;
        end
        tsac_pkg::TSAC_K_CHAR: if (rx_open_q) begin
          if (!tsac_pkg::tsac_char_ok(link.an_char) ||
              rx_cnt_q == 4'(tsac_pkg::TSAC_FRAME_BYTES)) begin
            rx_bad_q <= 1'b1;
          end else begin
            rx_buf_q[rx_cnt_q] <= link.an_char[8:1];
            rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_crc_q <= tsac_pkg::tsac_crc_byte(rx_crc_q,
                                                link.an_char[8:1]);
          end
        end
        tsac_pkg::TSAC_K_EOF: rx_open_q <= 1'b0;
        default: rx_bad_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_len_out <= 4'h0;
      rsp_data_out <= 64'h0000_0000_0000_0000;
      rsp_crc_ok_out <= 1'b0;
    end else begin
      rsp_valid_out <= link.an_valid && rx_open_q &&
                       (link.an_kind == tsac_pkg::TSAC_K_EOF);
      if (link.an_valid && rx_open_q &&
          link.an_kind == tsac_pkg::TSAC_K_EOF) begin
        rsp_len_out <= (rx_cnt_q >= 4'(tsac_pkg::TSAC_CRC_BYTES)) ?
                       rx_cnt_q - 4'(tsac_pkg::TSAC_CRC_BYTES) : 4'h0;
        rsp_crc_ok_out <= !rx_bad_q &&
                          (rx_cnt_q >= tsac_pkg::TSAC_MIN_FRAME) &&
                          (rx_crc_q == tsac_pkg::TSAC_CRC_RESIDUE);
        for (int i = 0; i < tsac_pkg::TSAC_BUF_BYTES; i++) begin
          rsp_data_out[8*i +: 8] <= rx_buf_q[i];
        end
      end
    end
  end

endmodule : tsac_reader

// *** rtl/tsac_tag.sv ***
// tag end: frame check, state machine and anticollision responder
//
// Overview of operation
// - characters are ten bits, start bit first
// - reader frames: sof, data, two crc, eof
// - bad crc or unknown command: silence
// - replies framed sof, data, crc, eof
// - no field power means no answers
// - power-up loads random id, enters ready
// - initiate in ready goes to inventory
// - inventory answers anticollision commands, stays
// - matching select in inventory selects tag
// - selected runs memory commands, no anticollision
// - selected: mismatch deselects, completion deactivates
// - deselected wakes only on matching select
// - deactivated ignores all until power loss
// - eight-bit id reloaded on initiate in inventory, kept on initiate in ready
// - low id nibble is the slot code
// - slot-zero poll redraws slot, answers zero
// - slot poll answers on slot match
// - reader runs sixteen slots, zero then 1-15
// - initiate answered at once with id
// - reader selects tag before memory access
// - only one tag selected at once
// - fixed id option disables random id
`timescale 1ns/1ns
module tsac_tag #(
  parameter bit FIXED_ID_EN = 1'b0,
  parameter logic [7:0] FIXED_ID = 8'h00
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic field_ok_in,
  tsac_link_if.tag link,
  output logic access_valid_out,
  output logic [7:0] access_op_out,
  output logic [39:0] access_arg_out,
  input wire logic access_rsp_valid_in,
  input wire logic [3:0] access_rsp_len_in,
  input wire logic [63:0] access_rsp_data_in,
  output tsac_pkg::tsac_state_t state_out,
  output logic [7:0] select_identifier_out
);

  tsac_pkg::tsac_state_t state_q;
  tsac_pkg::tsac_state_t state_d;
  logic [7:0] id_q;
  logic [7:0] id_d;
  logic [15:0] lfsr_q;

  logic rx_open_q;
  logic rx_bad_q;
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic [7:0] rx_buf_q [tsac_pkg::TSAC_BUF_BYTES];
  logic rx_done_q;
  logic [3:0] rx_len_q;
  logic rx_listen;
  logic rx_char_take;

  logic acc_wait_q;
  logic tx_busy;
  logic reply_go;
  logic acc_go;
  logic tx_start;
  logic [3:0] tx_len;
  logic [63:0] tx_data;

  logic [7:0] op;
  logic [7:0] arg;
  logic [7:0] fresh_id;
  logic [3:0] fresh_slot;
  logic is_init;
  logic is_pcall;
  logic is_slot;
  logic is_sel;
  logic sel_match;
  logic is_comp;
  logic is_access;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lfsr_q <= tsac_pkg::TSAC_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & tsac_pkg::TSAC_LFSR_TAPS)};
    end
  end

  assign fresh_id = FIXED_ID_EN ? FIXED_ID : lfsr_q[7:0];
  assign fresh_slot = FIXED_ID_EN ? FIXED_ID[3:0] : lfsr_q[11:8];

  // listen only while powered and idle
  assign rx_listen = field_ok_in && !tx_busy && !acc_wait_q &&
                     (state_q != tsac_pkg::TSAC_ST_OFF);
  assign rx_char_take = link.rq_valid && rx_listen && rx_open_q &&
                        (link.rq_kind == tsac_pkg::TSAC_K_CHAR);

  // request deframer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !field_ok_in) begin
      rx_open_q <= 1'b0;
      rx_bad_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_crc_q <= tsac_pkg::TSAC_CRC_INIT;
    end else if (link.rq_valid && rx_listen) begin
      unique case (link.rq_kind)
        tsac_pkg::TSAC_K_SOF: begin
          rx_open_q <= 1'b1;
          rx_bad_q <= 1'b0;
          rx_cnt_q <= 4'h0;
          rx_crc_q <= tsac_pkg::TSAC_CRC_INIT;
        end
        // start low, stop high, else frame bad
        tsac_pkg::TSAC_K_CHAR: if (rx_open_q) begin
          if (!tsac_pkg::tsac_char_ok(link.rq_char) ||
              rx_cnt_q == 4'(tsac_pkg::TSAC_BUF_BYTES)) begin
            rx_bad_q <= 1'b1;
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_crc_q <= tsac_pkg::tsac_crc_byte(rx_crc_q,
                                                link.rq_char[8:1]);
          end
        end
        tsac_pkg::TSAC_K_EOF: rx_open_q <= 1'b0;
        default: rx_bad_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rx_char_take && rx_cnt_q < 4'(tsac_pkg::TSAC_BUF_BYTES)) begin
      rx_buf_q[rx_cnt_q[2:0]] <= link.rq_char[8:1];
    end
  end

  // only good crc and framing reach the decoder
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !field_ok_in) begin
      rx_done_q <= 1'b0;
      rx_len_q <= 4'h0;
    end else begin
      rx_done_q <= link.rq_valid && rx_listen && rx_open_q &&
                   (link.rq_kind == tsac_pkg::TSAC_K_EOF) &&
                   !rx_bad_q && (rx_cnt_q >= tsac_pkg::TSAC_MIN_FRAME) &&
                   (rx_crc_q == tsac_pkg::TSAC_CRC_RESIDUE);
      rx_len_q <= rx_cnt_q - 4'(tsac_pkg::TSAC_CRC_BYTES);
    end
  end

  // unknown codes or lengths match nothing
  always_comb begin
    op = rx_buf_q[0];
    arg = rx_buf_q[1];
    is_init = (op == tsac_pkg::TSAC_OP_ANTICOL) &&
              (rx_len_q == tsac_pkg::TSAC_LEN_ANTICOL) &&
              (arg == tsac_pkg::TSAC_ARG_INIT);
    is_pcall = (op == tsac_pkg::TSAC_OP_ANTICOL) &&
               (rx_len_q == tsac_pkg::TSAC_LEN_ANTICOL) &&
               (arg == tsac_pkg::TSAC_ARG_PCALL);
    is_slot = (op[3:0] == tsac_pkg::TSAC_SLOT_MARK) &&
              (op[7:4] != tsac_pkg::TSAC_SLOT_ZERO) &&
              (rx_len_q == tsac_pkg::TSAC_LEN_SLOT);
    is_sel = (op == tsac_pkg::TSAC_OP_SELECT) &&
             (rx_len_q == tsac_pkg::TSAC_LEN_SELECT);
    sel_match = (arg == id_q);
    is_comp = (op == tsac_pkg::TSAC_OP_COMPLETE) &&
              (rx_len_q == tsac_pkg::TSAC_LEN_COMPLETE);
    is_access = ((op == tsac_pkg::TSAC_OP_READ) &&
                 (rx_len_q == tsac_pkg::TSAC_LEN_READ)) ||
                ((op == tsac_pkg::TSAC_OP_WRITE) &&
                 (rx_len_q == tsac_pkg::TSAC_LEN_WRITE)) ||
                ((op == tsac_pkg::TSAC_OP_AUTH) &&
                 (rx_len_q == tsac_pkg::TSAC_LEN_AUTH)) ||
                ((op == tsac_pkg::TSAC_OP_UID) &&
                 (rx_len_q == tsac_pkg::TSAC_LEN_UID));
  end

  // anything not listed leaves state and id alone
  always_comb begin
    state_d = state_q;
    id_d = id_q;
    reply_go = 1'b0;
    acc_go = 1'b0;
    if (!field_ok_in) begin
      // field loss powers the tag off
      state_d = tsac_pkg::TSAC_ST_OFF;
    end else begin
      unique case (state_q)
        tsac_pkg::TSAC_ST_OFF: begin
          state_d = tsac_pkg::TSAC_ST_READY;
          id_d = fresh_id;
        end
        tsac_pkg::TSAC_ST_READY: if (rx_done_q && is_init) begin
          state_d = tsac_pkg::TSAC_ST_INV;
          reply_go = 1'b1;
        end
        tsac_pkg::TSAC_ST_INV: if (rx_done_q) begin
          if (is_init) begin
            id_d = fresh_id;
            reply_go = 1'b1;
          end else if (is_pcall) begin
            // redraw slot code, answer on zero
            id_d = {id_q[7:4], fresh_slot};
            reply_go = (fresh_slot == tsac_pkg::TSAC_SLOT_ZERO);
          end else if (is_slot) begin
            reply_go = (op[7:4] == id_q[3:0]);
          end else if (is_sel && sel_match) begin
            state_d = tsac_pkg::TSAC_ST_SEL;
            reply_go = 1'b1;
          end
        end
        tsac_pkg::TSAC_ST_SEL: if (rx_done_q) begin
          if (is_sel && sel_match) begin
            reply_go = 1'b1;
          end else if (is_sel) begin
            state_d = tsac_pkg::TSAC_ST_DESEL;
          end else if (is_comp) begin
            state_d = tsac_pkg::TSAC_ST_DEACT;
          end else if (is_access) begin
            acc_go = 1'b1;
          end
        end
        tsac_pkg::TSAC_ST_DESEL: if (rx_done_q && is_sel && sel_match) begin
          state_d = tsac_pkg::TSAC_ST_SEL;
          reply_go = 1'b1;
        end
        tsac_pkg::TSAC_ST_DEACT: state_d = tsac_pkg::TSAC_ST_DEACT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q <= tsac_pkg::TSAC_ST_OFF;
      id_q <= 8'h00;
    end else begin
      state_q <= state_d;
      id_q <= id_d;
    end
  end

  // memory access hand-off to the user side
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      access_valid_out <= 1'b0;
      access_op_out <= 8'h00;
      access_arg_out <= 40'h00_0000_0000;
      acc_wait_q <= 1'b0;
    end else begin
      access_valid_out <= acc_go;
      if (acc_go) begin
        access_op_out <= op;
        access_arg_out <= {rx_buf_q[5], rx_buf_q[4], rx_buf_q[3],
                           rx_buf_q[2], rx_buf_q[1]};
      end
      if (acc_go) begin
        acc_wait_q <= 1'b1;
      end else if (access_rsp_valid_in || !field_ok_in) begin
        acc_wait_q <= 1'b0;
      end
    end
  end

  // id replies start right after the request
  assign tx_start = field_ok_in && (reply_go ||
                    (acc_wait_q && access_rsp_valid_in &&
                     access_rsp_len_in != 4'h0));
  assign tx_len = reply_go ? tsac_pkg::TSAC_LEN_ID_REPLY : access_rsp_len_in;
  assign tx_data = reply_go ? {56'h0, id_d} : access_rsp_data_in;

  tsac_framer u_framer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .abort_in(!field_ok_in),
    .start_in(tx_start),
    .len_in(tx_len),
    .data_in(tx_data),
    .busy_out(tx_busy),
    .valid_out(link.an_valid),
    .kind_out(link.an_kind),
    .char_out(link.an_char)
  );

  assign state_out = state_q;
  assign select_identifier_out = id_q;

endmodule : tsac_tag
